//--- hdl/power_save_consts.vh
// Constants for the power-save controller: register map, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from the design file.
`ifndef POWER_SAVE_CONSTS_VH
`define POWER_SAVE_CONSTS_VH

// -----------------------------------------------------------------------
// Register map (byte addresses)
// -----------------------------------------------------------------------
`define PS_ADDR_CONTROL 8'h00
`define PS_ADDR_PROTECT 8'h04
`define PS_ADDR_STATUS 8'h08

// -----------------------------------------------------------------------
// Control field positions
// -----------------------------------------------------------------------
`define PS_BIT_CLKDIS_HI 7
`define PS_BIT_CLKDIS_LO 6
`define PS_BIT_TIMEBASE_CLOCK_SELECT 5
`define PS_BIT_EXTCLK 4
`define PS_BIT_IDLE 2
`define PS_BIT_STOP 1
`define PS_CTRL_MASK 8'hf6
`define PS_CTRL_RESET 8'h00

// -----------------------------------------------------------------------
// Protection unlock key and timing
// -----------------------------------------------------------------------
`define PS_UNLOCK_KEY 8'ha5
`define PS_TBC_SHIFT_LO 8
`define PS_TBC_SHIFT_HI 9
`define PS_PREFETCH_DEPTH 4

`endif

//--- hdl/power_save_mode_controller.v
// Power-save mode controller: HALT, IDLE, software STOP and clock output
// inhibit, with a protected 8-bit control register on AHB-Lite.
// Assumes the CPU pulses halt_exec, the interrupt controller supplies
// request levels, and a clock cell gates clocks on the enables given.
`timescale 1ns/1ps
`default_nettype none
`include "power_save_consts.vh"

// Behaviour
// - HALT stops CPU clock only, oscillator runs
// - HALT entered only by halt instruction
// - IDLE stops system clock, oscillator keeps running
// - IDLE exit resumes at once, no wait
// - STOP halts oscillator, PLL and all clocks
// - STOP release in PLL mode waits stabilization
// - External clock keeps oscillator off; direct uses neither
// - Control register written only after unlock sequence
// - Register supports byte and single bit access
// - Bits 7:6 select clock output or inhibit
// - Bit 5 selects time base divide 2^8/2^9
// - Bit 4 external clock: cut loop, skip count
// - Bit 2 enters IDLE, cleared on release
// - Bit 1 enters STOP, wins over IDLE
// - HALT keeps state and CPU-independent peripherals
// - Fetch until prefetch queue full, then freeze
// - HALT keeps bus and clock output alive
// - HALT exit on NMI, unmasked interrupt, reset
// - Lower priority wake: exit, keep request pending
// - Higher priority wake: exit and acknowledge
// - NMI branches; maskable follows enable state
// - Reset release equals ordinary reset
// - IDLE exit only on NMI or reset
module power_save_mode_controller #(
	parameter STAB_COUNT_LO = 256,
	parameter STAB_COUNT_HI = 512
) (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// CPU and interrupt controller
	input wire halt_exec,
	input wire prefetch_push,
	input wire nmi_pin,
	input wire irq_unmasked,
	input wire irq_higher_prio,
	input wire in_isr,
	input wire interrupts_enabled_state,
	input wire clock_mode_pin,
	// Clock gate controls
	output reg osc_enable,
	output reg pll_enable,
	output reg osc_feedback_cut,
	output reg cpu_clk_enable,
	output reg periph_clk_enable,
	output reg system_clock_output_pin_enable,
	output reg timebase_clock_select,
	// Wake outcome
	output reg irq_acknowledge,
	output reg irq_hold_pending,
	output reg fetch_enable
);

	// -------------------------------------------------------------------
	// States
	// -------------------------------------------------------------------
	localparam [2:0] ST_RUN = 3'd0;
	localparam [2:0] ST_FILL = 3'd1;
	localparam [2:0] ST_HALT = 3'd2;
	localparam [2:0] ST_IDLE = 3'd3;
	localparam [2:0] ST_STOP = 3'd4;
	localparam [2:0] ST_STAB = 3'd5;

	reg [2:0] state_q, state_d;
	reg [7:0] ctrl_q, ctrl_d;
	reg unlock_q, unlock_d;
	reg [9:0] stab_q, stab_d;
	reg [2:0] fill_q, fill_d;
	reg direct_q;
	reg strap_taken_q;
	reg [1:0] strap_age_q;
	reg nmi_s1_q, nmi_s2_q, nmi_s3_q;
	reg irq_s1_q, irq_s2_q;
	reg mode_s1_q, mode_s2_q;
	reg ph_we_q, ph_re_q;
	reg [7:0] ph_addr_q;
	reg gate_cpu_d, gate_per_d;
	reg ack_d, pend_d;
	wire nmi_edge;
	wire bus_go;
	wire [7:0] wbyte;

	assign nmi_edge = nmi_s2_q & ~nmi_s3_q;
	assign bus_go = hsel & htrans[1] & hready;
	assign wbyte = hwdata[7:0];

	// -------------------------------------------------------------------
	// Input synchronisers and strap capture
	// -------------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nmi_s1_q <= 1'b0;
			nmi_s2_q <= 1'b0;
			nmi_s3_q <= 1'b0;
			irq_s1_q <= 1'b0;
			irq_s2_q <= 1'b0;
			mode_s1_q <= 1'b0;
			mode_s2_q <= 1'b0;
			direct_q <= 1'b0;
			strap_taken_q <= 1'b0;
			strap_age_q <= 2'd0;
		end else begin
			nmi_s1_q <= nmi_pin;
			nmi_s2_q <= nmi_s1_q;
			nmi_s3_q <= nmi_s2_q;
			irq_s1_q <= irq_unmasked;
			irq_s2_q <= irq_s1_q;
			mode_s1_q <= clock_mode_pin;
			mode_s2_q <= mode_s1_q;
			// Let the strap pass both sync stages before using it
			if (strap_age_q != 2'd2)
				strap_age_q <= strap_age_q + 2'd1;
			// Mode strap caught once after reset release
			if (!strap_taken_q && strap_age_q == 2'd2) begin
				direct_q <= mode_s2_q;
				strap_taken_q <= 1'b1;
			end
		end
	end

	// -------------------------------------------------------------------
	// Bus address phase capture
	// -------------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_we_q <= 1'b0;
			ph_re_q <= 1'b0;
			ph_addr_q <= 8'h00;
		end else begin
			// Data phase follows the accepted address phase
			ph_we_q <= bus_go & hwrite;
			ph_re_q <= bus_go & ~hwrite;
			if (bus_go)
				ph_addr_q <= haddr;
		end
	end

	// -------------------------------------------------------------------
	// Register and mode next state
	// -------------------------------------------------------------------
	always @* begin
		state_d = state_q;
		ctrl_d = ctrl_q;
		unlock_d = unlock_q;
		stab_d = stab_q;
		fill_d = fill_q;
		ack_d = 1'b0;
		pend_d = 1'b0;
		// Protected write: unlock key first, next write commits
		if (ph_we_q && ph_addr_q == `PS_ADDR_PROTECT) begin
			unlock_d = (wbyte == `PS_UNLOCK_KEY);
		end else if (ph_we_q && ph_addr_q == `PS_ADDR_CONTROL) begin
			unlock_d = 1'b0;
			// Byte write covers bit ops done as read-modify-write
			if (unlock_q)
				ctrl_d = wbyte & `PS_CTRL_MASK;
			// Without unlock the write is dropped
		end else if (ph_we_q) begin
			// Any other write closes the unlock window
			unlock_d = 1'b0;
		end
		case (state_q)
		ST_RUN: begin
			// Only the halt instruction enters HALT
			if (halt_exec) begin
				state_d = ST_FILL;
				fill_d = 3'd0;
			end else if (ctrl_q[`PS_BIT_STOP]) begin
				state_d = ST_STOP;
			end else if (ctrl_q[`PS_BIT_IDLE]) begin
				state_d = ST_IDLE;
			end
		end
		ST_FILL: begin
			// Keep fetching until the prefetch queue is full
			if (prefetch_push)
				fill_d = fill_q + 3'd1;
			if (fill_q == 3'd`PS_PREFETCH_DEPTH)
				state_d = ST_HALT;
		end
		ST_HALT: begin
			// Wake on NMI or unmasked interrupt
			if (nmi_edge || irq_s2_q) begin
				state_d = ST_RUN;
				// Priority and enable state decide the outcome
				if (nmi_edge || (irq_higher_prio && in_isr) ||
					(!in_isr && interrupts_enabled_state))
					ack_d = 1'b1;
				else
					// Lower priority or disabled: leave it pending
					pend_d = 1'b1;
			end
		end
		ST_IDLE: begin
			// Only NMI releases IDLE; resume with no wait
			if (nmi_edge) begin
				state_d = ST_RUN;
				ctrl_d[`PS_BIT_IDLE] = 1'b0;
				ack_d = ~in_isr;
				pend_d = in_isr;
			end
		end
		ST_STOP: begin
			// Only an NMI edge leaves STOP
			if (nmi_edge) begin
				ctrl_d[`PS_BIT_IDLE] = 1'b0;
				ctrl_d[`PS_BIT_STOP] = 1'b0;
				// External clock or direct skips stabilization
				if (ctrl_q[`PS_BIT_EXTCLK] || direct_q) begin
					state_d = ST_RUN;
					ack_d = ~in_isr;
					pend_d = in_isr;
				end else begin
					state_d = ST_STAB;
					stab_d = ctrl_q[`PS_BIT_TIMEBASE_CLOCK_SELECT] ?
						STAB_COUNT_HI[9:0] : STAB_COUNT_LO[9:0];
				end
			end
		end
		ST_STAB: begin
			// Time base count before resuming
			if (stab_q <= 10'd1) begin
				state_d = ST_RUN;
				ack_d = ~in_isr;
				pend_d = in_isr;
			end else begin
				stab_d = stab_q - 10'd1;
			end
		end
		default: state_d = ST_RUN;
		endcase
	end

	// -------------------------------------------------------------------
	// Clock enables per mode
	// -------------------------------------------------------------------
	always @* begin
		// HALT stops CPU only; peripherals keep running
		gate_cpu_d = (state_q == ST_RUN) || (state_q == ST_FILL);
		// IDLE, STOP and stabilization stop everything
		gate_per_d = (state_q == ST_RUN) || (state_q == ST_FILL) ||
			(state_q == ST_HALT);
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_RUN;
			ctrl_q <= `PS_CTRL_RESET;
			unlock_q <= 1'b0;
			stab_q <= 10'd0;
			fill_q <= 3'd0;
		end else begin
			state_q <= state_d;
			ctrl_q <= ctrl_d;
			unlock_q <= unlock_d;
			stab_q <= stab_d;
			fill_q <= fill_d;
		end
	end

	// Gates change on the falling edge, while the gated clock is low
	always @(negedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_clk_enable <= 1'b1;
			periph_clk_enable <= 1'b1;
		end else begin
			cpu_clk_enable <= gate_cpu_d;
			periph_clk_enable <= gate_per_d;
		end
	end

	// -------------------------------------------------------------------
	// Oscillator, PLL and outputs
	// -------------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_enable <= 1'b0;
			pll_enable <= 1'b0;
			osc_feedback_cut <= 1'b0;
			system_clock_output_pin_enable <= 1'b1;
			timebase_clock_select <= 1'b0;
			irq_acknowledge <= 1'b0;
			irq_hold_pending <= 1'b0;
			fetch_enable <= 1'b1;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			// Resonator runs unless STOP, external or direct
			osc_enable <= ~direct_q & ~ctrl_q[`PS_BIT_EXTCLK] &
				(state_q != ST_STOP);
			pll_enable <= ~direct_q & (state_q != ST_STOP);
			osc_feedback_cut <= ctrl_q[`PS_BIT_EXTCLK] &
				(state_q == ST_STOP);
			// Output pin runs in RUN and HALT unless inhibited
			system_clock_output_pin_enable <= gate_per_d &
				~(ctrl_q[`PS_BIT_CLKDIS_HI] & ctrl_q[`PS_BIT_CLKDIS_LO]);
			timebase_clock_select <= ctrl_q[`PS_BIT_TIMEBASE_CLOCK_SELECT];
			// Wake outcome pulses stand for one cycle
			irq_acknowledge <= ack_d;
			irq_hold_pending <= pend_d;
			fetch_enable <= gate_cpu_d;
			// Zero wait states, always OKAY
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			// Read data stands in the data phase
			if (bus_go && !hwrite) begin
				case (haddr)
				`PS_ADDR_CONTROL: hrdata <= {24'h000000, ctrl_d};
				`PS_ADDR_PROTECT: hrdata <= {31'h00000000, unlock_d};
				`PS_ADDR_STATUS: hrdata <= {28'h0000000, direct_q,
					state_d};
				default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

//--- verif/cpu_side_model.sv
// CPU side model: fills the prefetch queue after a halt instruction
// and holds the clock mode strap. Assumes one clock shared with the DUT.
`timescale 1ns/1ps
`default_nettype none
`include "power_save_consts.vh"
module cpu_side_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// From CPU and controller
	input wire logic halt_exec,
	input wire logic fetch_enable,
	// To controller
	output logic prefetch_push,
	output logic clock_mode_pin
);
	logic [2:0] left_q;
	assign clock_mode_pin = 1'b0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			left_q <= 3'h0;
			prefetch_push <= 1'b0;
		end else begin
			prefetch_push <= fetch_enable && (halt_exec || left_q != 3'h0);
			if (halt_exec) left_q <= 3'(`PS_PREFETCH_DEPTH) - 3'h1;
			else if (left_q != 3'h0) left_q <= left_q - 3'h1;
		end
	end
endmodule
`default_nettype wire

//--- verif/power_save_mode_controller_bench.sv
// Bench: AHB-Lite register tasks and mode sequences.
// Assumes the DUT header and the CPU side model.
`timescale 1ns/1ps
`default_nettype none
`include "power_save_consts.vh"
module power_save_mode_controller_bench;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010;
	logic [31:0] hwdata = 32'h0, q;
	logic halt_exec = 1'b0, nmi_pin = 1'b0, irq_unmasked = 1'b0;
	logic irq_higher_prio = 1'b0, in_isr = 1'b0, ien = 1'b0;
	wire [31:0] hrdata;
	wire hreadyout, hresp, osc_enable, pll_enable, cpu_clk_enable;
	wire periph_clk_enable, clkpin_en, timebase_clock_select, ack, pend;
	wire fetch_enable, prefetch_push, clock_mode_pin, osc_feedback_cut;
	int n_fail = 0, n_checks = 0, cyc = 0, ack_n = 0, pend_n = 0;
	always #5 hclk = ~hclk;
	power_save_mode_controller #(.STAB_COUNT_LO(4), .STAB_COUNT_HI(8))
		u_power_save_mode_controller (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.halt_exec(halt_exec), .prefetch_push(prefetch_push),
		.nmi_pin(nmi_pin), .irq_unmasked(irq_unmasked),
		.irq_higher_prio(irq_higher_prio), .in_isr(in_isr),
		.interrupts_enabled_state(ien), .clock_mode_pin(clock_mode_pin),
		.osc_enable(osc_enable), .pll_enable(pll_enable),
		.osc_feedback_cut(osc_feedback_cut),
		.cpu_clk_enable(cpu_clk_enable),
		.periph_clk_enable(periph_clk_enable),
		.system_clock_output_pin_enable(clkpin_en),
		.timebase_clock_select(timebase_clock_select),
		.irq_acknowledge(ack), .irq_hold_pending(pend),
		.fetch_enable(fetch_enable));
	cpu_side_model u_cpu_side_model (.hclk(hclk), .hresetn(hresetn),
		.halt_exec(halt_exec), .fetch_enable(fetch_enable),
		.prefetch_push(prefetch_push), .clock_mode_pin(clock_mode_pin));
	task automatic report_and_stop;
		if (n_fail == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (ack === 1'b1) ack_n++;
		if (pend === 1'b1) pend_n++;
		if (cyc == 20000) begin
			n_fail++;
			report_and_stop;
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
		chk(32'(hresp), 32'h0);
	endtask
	task automatic pw(input logic [31:0] d);
		bus(1'b1, `PS_ADDR_PROTECT, 32'(`PS_UNLOCK_KEY));
		bus(1'b1, `PS_ADDR_CONTROL, d);
		@(posedge hclk);
		@(negedge hclk);
	endtask
	// Wait up to lim cycles for a clock enable, then compare it
	task automatic wt(input logic p, input logic v, input int lim);
		for (int i = 0; i < lim; i++)
			if ((p ? periph_clk_enable : cpu_clk_enable) !== v)
				@(posedge hclk);
		chk(32'(p ? periph_clk_enable : cpu_clk_enable), 32'(v));
	endtask
	task automatic hlt(input logic isr, input logic en, input logic hi);
		@(posedge hclk);
		in_isr <= isr;
		ien <= en;
		irq_higher_prio <= hi;
		halt_exec <= 1'b1;
		@(posedge hclk);
		halt_exec <= 1'b0;
		wt(1'b0, 1'b0, 20);
		chk(32'(periph_clk_enable && osc_enable && pll_enable), 32'h1);
		chk(32'(clkpin_en), 32'h1);
		@(posedge hclk);
		irq_unmasked <= 1'b1;
		wt(1'b0, 1'b1, 10);
		irq_unmasked <= 1'b0;
		repeat (4) @(posedge hclk);
	endtask
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (5) @(posedge hclk);
		rd(`PS_ADDR_CONTROL, 32'h0);
		rd(8'h0c, 32'h0);
		bus(1'b1, `PS_ADDR_CONTROL, 32'h20);
		rd(`PS_ADDR_CONTROL, 32'h0);
		bus(1'b1, `PS_ADDR_PROTECT, 32'(`PS_UNLOCK_KEY));
		bus(1'b1, 8'h0c, 32'h0);
		bus(1'b1, `PS_ADDR_CONTROL, 32'h20);
		rd(`PS_ADDR_CONTROL, 32'h0);
		pw(32'h20);
		chk(32'(timebase_clock_select), 32'h1);
		rd(`PS_ADDR_CONTROL, 32'h20);
		pw(32'hc0);
		chk(32'(clkpin_en), 32'h0);
		pw(32'h00);
		chk(32'(clkpin_en), 32'h1);
		pw(32'h10);
		chk(32'(osc_enable), 32'h0);
		chk(32'(pll_enable), 32'h1);
		pw(32'h00);
		hlt(1'b1, 1'b1, 1'b0);
		chk(32'(pend_n), 32'h1);
		hlt(1'b1, 1'b1, 1'b1);
		chk(32'(ack_n), 32'h1);
		hlt(1'b0, 1'b0, 1'b0);
		chk(32'(pend_n), 32'h2);
		hlt(1'b0, 1'b1, 1'b0);
		chk(32'(ack_n), 32'h2);
		pw(32'h04);
		wt(1'b1, 1'b0, 10);
		chk(32'(osc_enable && pll_enable), 32'h1);
		@(posedge hclk);
		irq_unmasked <= 1'b1;
		repeat (10) @(posedge hclk);
		chk(32'(periph_clk_enable), 32'h0);
		chk(32'(clkpin_en), 32'h0);
		irq_unmasked <= 1'b0;
		nmi_pin <= 1'b1;
		wt(1'b1, 1'b1, 6);
		nmi_pin <= 1'b0;
		rd(`PS_ADDR_CONTROL, 32'h0);
		pw(32'h06);
		wt(1'b1, 1'b0, 10);
		@(negedge hclk);
		chk(32'(osc_enable || pll_enable), 32'h0);
		@(posedge hclk);
		nmi_pin <= 1'b1;
		repeat (3) @(posedge hclk);
		nmi_pin <= 1'b0;
		repeat (2) @(posedge hclk);
		chk(32'(periph_clk_enable), 32'h0);
		wt(1'b1, 1'b1, 40);
		rd(`PS_ADDR_CONTROL, 32'h0);
		pw(32'h22);
		wt(1'b1, 1'b0, 10);
		chk(32'(osc_feedback_cut), 32'h0);
		@(posedge hclk);
		nmi_pin <= 1'b1;
		repeat (3) @(posedge hclk);
		nmi_pin <= 1'b0;
		repeat (6) @(posedge hclk);
		chk(32'(periph_clk_enable), 32'h0);
		wt(1'b1, 1'b1, 40);
		rd(`PS_ADDR_CONTROL, 32'h20);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(negedge hclk);
		chk(32'(timebase_clock_select), 32'h0);
		rd(`PS_ADDR_CONTROL, 32'h0);
		report_and_stop;
	end
endmodule
`default_nettype wire

//--- verif/ps_asserts.sv
// Port checker for the power-save controller.
// Assumes the bench drives the bus and a CPU model the fill pushes.
`timescale 1ns/1ps
`default_nettype none
module ps_asserts (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Watched ports
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic halt_exec,
	input wire logic nmi_pin,
	input wire logic clock_mode_pin,
	input wire logic pll_enable,
	input wire logic osc_enable,
	input wire logic cpu_clk_enable,
	input wire logic periph_clk_enable,
	input wire logic timebase_clock_select,
	input wire logic irq_acknowledge,
	input wire logic irq_hold_pending,
	input wire logic fetch_enable
);
	logic [2:0] age_q;
	logic up;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn) age_q <= 3'h0;
		else if (age_q != 3'h7) age_q <= age_q + 3'h1;
	assign up = age_q == 3'h7;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_halt_pll_on: assert property (
		up && !clock_mode_pin && periph_clk_enable && !cpu_clk_enable
		|-> pll_enable) else $error("pll off in halt");
	a_fill_fetch: assert property (
		halt_exec |=> fetch_enable [*3]) else $error("fill cut short");
	a_idle_all_off: assert property (
		!periph_clk_enable |-> !cpu_clk_enable) else $error("cpu ran");
	a_stop_osc_off: assert property (
		up && !clock_mode_pin && !pll_enable
		|-> !periph_clk_enable && !osc_enable) else $error("stop leak");
	a_nmi_wakes: assert property (
		$rose(nmi_pin) && !cpu_clk_enable |-> ##[1:40] cpu_clk_enable)
		else $error("no wake on nmi");
	a_ack_or_pend: assert property (
		!(irq_acknowledge && irq_hold_pending)) else $error("ack and pend");
	a_ack_pulse: assert property (
		irq_acknowledge |=> !irq_acknowledge) else $error("ack too long");
	a_cpu_frozen: assert property (
		up && !cpu_clk_enable |=> !fetch_enable) else $error("fetch running");
	a_timebase_clock_select_by_write: assert property (
		$changed(timebase_clock_select)
		|-> $past(hsel && hwrite && htrans[1], 3)) else $error("stray timebase_clock_select");
endmodule
bind power_save_mode_controller ps_asserts u_ps_asserts (
	.hclk(hclk),
	.hresetn(hresetn),
	.hsel(hsel),
	.htrans(htrans),
	.hwrite(hwrite),
	.halt_exec(halt_exec),
	.nmi_pin(nmi_pin),
	.clock_mode_pin(clock_mode_pin),
	.pll_enable(pll_enable),
	.osc_enable(osc_enable),
	.cpu_clk_enable(cpu_clk_enable),
	.periph_clk_enable(periph_clk_enable),
	.timebase_clock_select(timebase_clock_select),
	.irq_acknowledge(irq_acknowledge),
	.irq_hold_pending(irq_hold_pending),
	.fetch_enable(fetch_enable)
);
`default_nettype wire
